// ===== verilog/loader_pkg.sv
// Constants, record layout and carrier types shared by the record loader and
// the value formatter. Assumes a single 100 MHz mclk domain.
package loader_pkg;

    // ------------------------------------------------------------------------
    // Record geometry
    // ------------------------------------------------------------------------
    localparam int NUM_CH = 16;
    localparam int REC_LEN = 20;
    localparam int LEN_W = 5;
    localparam logic [7:0] LAST_CH_INDEX = 8'h0F;
    localparam logic [4:0] REC_LEN_CNT = 5'h14;

    localparam int OFS_FIXED0 = 0;
    localparam int OFS_FIXED1 = 1;
    localparam int OFS_TYPE = 2;
    localparam int OFS_RANGE = 3;
    localparam int OFS_DIAG_EN = 4;
    localparam int OFS_HI_MSB = 8;
    localparam int OFS_HI_LSB = 9;
    localparam int OFS_LO_MSB = 10;
    localparam int OFS_LO_LSB = 11;
    localparam int BIT_WIRE_BREAK_EN = 0;
    localparam int BIT_LIMIT_EN = 1;

    // Contents of the two fixed leading bytes; the values are arbitrary.
    localparam logic [7:0] FIXED_BYTE0 = 8'h00;
    localparam logic [7:0] FIXED_BYTE1 = 8'h00;

    // ------------------------------------------------------------------------
    // Codes and value bounds
    // ------------------------------------------------------------------------
    localparam logic [7:0] TYPE_OFF = 8'h00;
    localparam logic [7:0] TYPE_CUR_2W = 8'h03;
    localparam logic [7:0] TYPE_CUR_4W = 8'h02;
    localparam logic [7:0] RANGE_0_20 = 8'h02;
    localparam logic [7:0] RANGE_4_20 = 8'h03;
    localparam logic [7:0] RANGE_BI_20 = 8'h04;

    localparam logic [15:0] HI_LIMIT_MAX = 16'h7EFE;
    localparam logic [15:0] LO_LIMIT_MIN_BI = 16'h8101;
    localparam logic [15:0] LO_LIMIT_MIN_UNI = 16'hED01;
    localparam logic [15:0] NOMINAL_FULL = 16'h6C00;
    localparam logic [15:0] VAL_OVERFLOW = 16'h7FFF;
    localparam logic [15:0] VAL_UNDERFLOW = 16'h8000;
    localparam logic [15:0] VAL_ZERO = 16'h0000;
    localparam logic [16:0] RAW_OVERSHOOT_MAX = 17'h07EFF;
    localparam logic [16:0] RAW_UNDER_MIN_BI = 17'h18100;
    localparam logic [16:0] RAW_UNDER_MIN_UNI = 17'h1ED00;
    // All sixteen bits are significant, so no low bit is masked off.
    localparam logic [15:0] ALIGN_MASK = 16'hFFFF;

    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_ERR_INDEX = 8'h01;
    localparam logic [7:0] ST_ERR_LENGTH = 8'h02;
    localparam logic [7:0] ST_ERR_FIXED = 8'h03;
    localparam logic [7:0] ST_ERR_TYPE = 8'h04;
    localparam logic [7:0] ST_ERR_RANGE = 8'h05;
    localparam logic [7:0] ST_ERR_WIRE_BREAK = 8'h06;
    localparam logic [7:0] ST_ERR_LIMIT = 8'h07;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    typedef logic [REC_LEN-1:0][7:0] rec_bytes_t;
    localparam rec_bytes_t REC_DEFAULT = {{(REC_LEN-2){8'h00}}, FIXED_BYTE1, FIXED_BYTE0};

    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RECV = 2'b01,
        WR_CHECK = 2'b10
    } wr_state_t;

    typedef struct packed {
        logic [7:0] meas_type;
        logic [7:0] meas_range;
        logic wire_break_en;
        logic limit_en;
        logic [15:0] hi_limit;
        logic [15:0] lo_limit;
    } chan_cfg_t;

    typedef struct packed {
        logic valid;
        logic first;
        logic last;
        logic [7:0] index;
        logic [7:0] data;
    } rec_wr_t;

    typedef struct packed {
        logic valid;
        logic [7:0] index;
        logic [7:0] code;
    } rec_status_t;

    typedef struct packed {
        logic valid;
        logic [7:0] index;
        logic [7:0] offset;
    } rd_req_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic [7:0] data;
    } rd_rsp_t;

    typedef struct packed {
        logic [15:0] value;
        logic overflow;
        logic underflow;
        logic wire_break;
        logic limit_hi;
        logic limit_lo;
    } chan_meas_t;

endpackage : loader_pkg

// ===== verilog/meas_value_formatter.sv
// One channel's value formatter: saturation, left alignment and limit flags.
// Assumes cfg was checked before it was applied and raw is on mclk.
`timescale 1ns/1ps
module meas_value_formatter (
    input wire logic mclk,
    input wire logic rst_n,
    input loader_pkg::chan_cfg_t cfg,
    input wire logic [16:0] raw,
    output loader_pkg::chan_meas_t meas
);

    loader_pkg::chan_meas_t meas_d;
    loader_pkg::chan_meas_t meas_q;
    logic [16:0] under_min;

    always_comb begin
        meas_d = '0;
        under_min = (cfg.meas_range == loader_pkg::RANGE_BI_20) ?
            loader_pkg::RAW_UNDER_MIN_BI : loader_pkg::RAW_UNDER_MIN_UNI;
        if (cfg.meas_type == loader_pkg::TYPE_OFF) begin
            meas_d.value = loader_pkg::VAL_ZERO;
        end else if ($signed(raw) > $signed(loader_pkg::RAW_OVERSHOOT_MAX)) begin
            meas_d.value = loader_pkg::VAL_OVERFLOW;
            meas_d.overflow = 1'b1;
        end else if ($signed(raw) < $signed(under_min)) begin
            // A broken loop reads as deep underflow; only 4..20 mA can tell.
            if (cfg.wire_break_en) begin
                meas_d.value = loader_pkg::VAL_OVERFLOW;
                meas_d.wire_break = 1'b1;
            end else begin
                meas_d.value = loader_pkg::VAL_UNDERFLOW;
                meas_d.underflow = 1'b1;
            end
        end else begin
            meas_d.value = raw[15:0] & loader_pkg::ALIGN_MASK;
        end
        if (cfg.limit_en && cfg.meas_type != loader_pkg::TYPE_OFF) begin
            meas_d.limit_hi = $signed(meas_d.value) > $signed(cfg.hi_limit);
            meas_d.limit_lo = $signed(meas_d.value) < $signed(cfg.lo_limit);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meas_q <= '0;
        end else begin
            meas_q <= meas_d;
        end
    end

    assign meas = meas_q;

endmodule : meas_value_formatter

// ===== verilog/channel_param_record_loader.sv
// Parameter record loader for a sixteen channel current input module.
// Assumes records arrive byte by byte on mclk from the controller side.
`timescale 1ns/1ps
module channel_param_record_loader (
    input wire logic mclk,
    input wire logic rst_n,
    input loader_pkg::rec_wr_t wr,
    input wire logic diag_readback_mode,
    input loader_pkg::rd_req_t rd,
    input wire logic [loader_pkg::NUM_CH-1:0][16:0] raw_sample,
    output logic wr_ready,
    output loader_pkg::rec_status_t status,
    output loader_pkg::rd_rsp_t rd_rsp,
    output loader_pkg::chan_meas_t [loader_pkg::NUM_CH-1:0] meas
);

    // ------------------------------------------------------------------------
    // Decoding shared by the checker and the channel configuration
    // ------------------------------------------------------------------------

    // The same byte positions are used whichever attachment carries the record.
    function automatic loader_pkg::chan_cfg_t rec_to_cfg(input loader_pkg::rec_bytes_t r);
        loader_pkg::chan_cfg_t c;
        c.meas_type = r[loader_pkg::OFS_TYPE];
        c.meas_range = r[loader_pkg::OFS_RANGE];
        c.wire_break_en = r[loader_pkg::OFS_DIAG_EN][loader_pkg::BIT_WIRE_BREAK_EN];
        c.limit_en = r[loader_pkg::OFS_DIAG_EN][loader_pkg::BIT_LIMIT_EN];
        c.hi_limit = {r[loader_pkg::OFS_HI_MSB], r[loader_pkg::OFS_HI_LSB]};
        c.lo_limit = {r[loader_pkg::OFS_LO_MSB], r[loader_pkg::OFS_LO_LSB]};
        return c;
    endfunction : rec_to_cfg

    function automatic logic range_known(input logic [7:0] rng);
        return rng == loader_pkg::RANGE_0_20 || rng == loader_pkg::RANGE_4_20 ||
            rng == loader_pkg::RANGE_BI_20;
    endfunction : range_known

    // Checks run in priority order; the first failing one names the error.
    function automatic logic [7:0] check_rec(
        input logic [7:0] idx,
        input logic [loader_pkg::LEN_W-1:0] cnt,
        input logic ovf,
        input loader_pkg::rec_bytes_t r
    );
        loader_pkg::chan_cfg_t c;
        logic [15:0] lo_min;
        logic [7:0] code;
        c = rec_to_cfg(r);
        lo_min = (c.meas_range == loader_pkg::RANGE_BI_20) ?
            loader_pkg::LO_LIMIT_MIN_BI : loader_pkg::LO_LIMIT_MIN_UNI;
        code = loader_pkg::ST_OK;
        if (idx > loader_pkg::LAST_CH_INDEX) begin
            code = loader_pkg::ST_ERR_INDEX;
        end else if (ovf || cnt != loader_pkg::REC_LEN_CNT) begin
            code = loader_pkg::ST_ERR_LENGTH;
        end else if (r[loader_pkg::OFS_FIXED0] != loader_pkg::FIXED_BYTE0 ||
                r[loader_pkg::OFS_FIXED1] != loader_pkg::FIXED_BYTE1) begin
            code = loader_pkg::ST_ERR_FIXED;
        end else if (c.meas_type == loader_pkg::TYPE_OFF) begin
            // A disabled channel ignores range, diagnostics and limits.
            code = loader_pkg::ST_OK;
        end else if (c.meas_type != loader_pkg::TYPE_CUR_2W &&
                c.meas_type != loader_pkg::TYPE_CUR_4W) begin
            code = loader_pkg::ST_ERR_TYPE;
        end else if (!range_known(c.meas_range)) begin
            code = loader_pkg::ST_ERR_RANGE;
        end else if (c.meas_type == loader_pkg::TYPE_CUR_2W &&
                c.meas_range != loader_pkg::RANGE_4_20) begin
            code = loader_pkg::ST_ERR_RANGE;
        end else if (c.wire_break_en && c.meas_range != loader_pkg::RANGE_4_20) begin
            code = loader_pkg::ST_ERR_WIRE_BREAK;
        end else if (c.limit_en) begin
            if ($signed(c.hi_limit) > $signed(loader_pkg::HI_LIMIT_MAX)) begin
                code = loader_pkg::ST_ERR_LIMIT;
            end else if ($signed(c.lo_limit) < $signed(lo_min)) begin
                code = loader_pkg::ST_ERR_LIMIT;
            end else if ($signed(c.hi_limit) <= $signed(c.lo_limit)) begin
                code = loader_pkg::ST_ERR_LIMIT;
            end
        end
        return code;
    endfunction : check_rec

    // ------------------------------------------------------------------------
    // Record reception and commit
    // ------------------------------------------------------------------------
    loader_pkg::wr_state_t st_d;
    loader_pkg::wr_state_t st_q;
    loader_pkg::rec_bytes_t buf_d;
    loader_pkg::rec_bytes_t buf_q;
    loader_pkg::rec_bytes_t rec_d [loader_pkg::NUM_CH];
    loader_pkg::rec_bytes_t rec_q [loader_pkg::NUM_CH];
    logic [loader_pkg::LEN_W-1:0] cnt_d;
    logic [loader_pkg::LEN_W-1:0] cnt_q;
    logic ovf_d;
    logic ovf_q;
    logic [7:0] idx_d;
    logic [7:0] idx_q;
    logic ready_d;
    logic ready_q;
    loader_pkg::rec_status_t status_d;
    loader_pkg::rec_status_t status_q;
    logic [7:0] check_code;

    assign check_code = check_rec(idx_q, cnt_q, ovf_q, buf_q);

    always_comb begin
        st_d = st_q;
        buf_d = buf_q;
        cnt_d = cnt_q;
        ovf_d = ovf_q;
        idx_d = idx_q;
        rec_d = rec_q;
        status_d = '0;
        case (st_q)
            loader_pkg::WR_IDLE: begin
                if (wr.valid && wr.first) begin
                    buf_d = loader_pkg::REC_DEFAULT;
                    buf_d[loader_pkg::OFS_FIXED0] = wr.data;
                    idx_d = wr.index;
                    cnt_d = loader_pkg::LEN_W'(1);
                    ovf_d = 1'b0;
                    st_d = wr.last ? loader_pkg::WR_CHECK : loader_pkg::WR_RECV;
                end
            end
            loader_pkg::WR_RECV: begin
                // Bytes are only collected here; nothing is judged yet.
                if (wr.valid) begin
                    if (cnt_q == loader_pkg::REC_LEN_CNT) begin
                        ovf_d = 1'b1;
                    end else begin
                        buf_d[cnt_q] = wr.data;
                        cnt_d = cnt_q + loader_pkg::LEN_W'(1);
                    end
                    if (wr.last) begin
                        st_d = loader_pkg::WR_CHECK;
                    end
                end
            end
            loader_pkg::WR_CHECK: begin
                status_d.valid = 1'b1;
                status_d.index = idx_q;
                status_d.code = check_code;
                if (check_code == loader_pkg::ST_OK) begin
                    rec_d[idx_q[3:0]] = buf_q;
                end
                st_d = loader_pkg::WR_IDLE;
            end
            default: begin
                st_d = loader_pkg::WR_IDLE;
            end
        endcase
        ready_d = (st_d != loader_pkg::WR_CHECK);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= loader_pkg::WR_IDLE;
            buf_q <= loader_pkg::REC_DEFAULT;
            cnt_q <= '0;
            ovf_q <= 1'b0;
            idx_q <= '0;
            ready_q <= 1'b0;
            status_q <= '0;
            for (int i = 0; i < loader_pkg::NUM_CH; i++) begin
                rec_q[i] <= loader_pkg::REC_DEFAULT;
            end
        end else begin
            st_q <= st_d;
            buf_q <= buf_d;
            cnt_q <= cnt_d;
            ovf_q <= ovf_d;
            idx_q <= idx_d;
            ready_q <= ready_d;
            status_q <= status_d;
            rec_q <= rec_d;
        end
    end

    assign wr_ready = ready_q;
    assign status = status_q;

    // ------------------------------------------------------------------------
    // Channel pipelines
    // ------------------------------------------------------------------------

    // Each channel reads only its own applied record, so a rewrite elsewhere
    // cannot disturb it.
    generate
        for (genvar ch = 0; ch < loader_pkg::NUM_CH; ch++) begin : g_chan
            meas_value_formatter u_fmt (
                .mclk(mclk),
                .rst_n(rst_n),
                .cfg(rec_to_cfg(rec_q[ch])),
                .raw(raw_sample[ch]),
                .meas(meas[ch])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Record read-back
    // ------------------------------------------------------------------------
    loader_pkg::rd_rsp_t rsp_d;
    loader_pkg::rd_rsp_t rsp_q;
    loader_pkg::rec_bytes_t rd_rec;
    loader_pkg::chan_meas_t rd_meas;

    always_comb begin
        rsp_d = '0;
        rd_rec = rec_q[rd.index[3:0]];
        rd_meas = meas[rd.index[3:0]];
        if (rd.valid) begin
            rsp_d.valid = 1'b1;
            if (rd.index > loader_pkg::LAST_CH_INDEX ||
                    rd.offset >= 8'(loader_pkg::REC_LEN)) begin
                rsp_d.err = 1'b1;
            end else if (diag_readback_mode && rd.index[3:1] == 3'h0 &&
                    rd.index[7:4] == 4'h0) begin
                // Diagnostic record: byte 0 holds the channel's underflow, overflow and wire-break flags.
                if (rd.offset == 8'(loader_pkg::OFS_FIXED0)) begin
                    rsp_d.data = {5'h00, rd_meas.underflow, rd_meas.overflow,
                        rd_meas.wire_break};
                end
            end else begin
                rsp_d.data = rd_rec[rd.offset[4:0]];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    assign rd_rsp = rsp_q;

endmodule : channel_param_record_loader

// ===== test/loader_checker.sv
// Port assertions for the parameter record loader.
// Assumes the single mclk domain and the synchronous active-low rst_n.
`timescale 1ns/1ps
module loader_checker (
    input wire logic mclk,
    input wire logic rst_n,
    input loader_pkg::rec_wr_t wr,
    input wire logic diag_readback_mode,
    input loader_pkg::rd_req_t rd,
    input wire logic [loader_pkg::NUM_CH-1:0][16:0] raw_sample,
    input wire logic wr_ready,
    input loader_pkg::rec_status_t status,
    input loader_pkg::rd_rsp_t rd_rsp,
    input loader_pkg::chan_meas_t [loader_pkg::NUM_CH-1:0] meas
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence rd_answered;
        rd.valid ##1 rd_rsp.valid;
    endsequence
    sequence rec_closed;
        wr.valid && wr.last ##2 status.valid;
    endsequence
    chk_rsp_follows_req: assert property (rd.valid |-> rd_answered)
        else $error("read request without answer");
    chk_rsp_no_spur: assert property (!rd.valid |=> !rd_rsp.valid)
        else $error("answer without read request");
    chk_bad_index_err: assert property (rd.valid && rd.index > 8'h0F
        |=> rd_rsp.err && rd_rsp.data == 8'h00)
        else $error("out of range read not refused");
    chk_status_after_rec: assert property (status.valid |-> $past(wr.valid && wr.last, 2))
        else $error("status without a completed record");
    chk_rec_gets_status: assert property (wr.valid && wr.last && wr_ready |-> rec_closed)
        else $error("record end without status");
    chk_ready_recovers: assert property (!wr_ready |=> wr_ready)
        else $error("write port held off too long");
    chk_status_code_known: assert property (status.valid |-> status.code <= 8'h07)
        else $error("undefined status code");
    chk_diag_other_zero: assert property (rd.valid && diag_readback_mode && rd.index < 8'h02
        && rd.offset != 8'h00 && rd.offset < 8'h14 |=> rd_rsp.data == 8'h00)
        else $error("diagnostic byte not zero");
    for (genvar i = 0; i < loader_pkg::NUM_CH; i++) begin : g_ch
        chk_ovf_saturate: assert property (meas[i].overflow |-> meas[i].value == 16'h7FFF)
            else $error("overflow value wrong");
        chk_udf_saturate: assert property (meas[i].underflow |-> meas[i].value == 16'h8000)
            else $error("underflow value wrong");
        chk_limit_exclusive: assert property (!(meas[i].limit_hi && meas[i].limit_lo))
            else $error("both limit flags set");
    end
endmodule : loader_checker

bind channel_param_record_loader loader_checker i_chk (.mclk(mclk), .rst_n(rst_n), .wr(wr),
    .diag_readback_mode(diag_readback_mode), .rd(rd), .raw_sample(raw_sample),
    .wr_ready(wr_ready), .status(status), .rd_rsp(rd_rsp), .meas(meas));

// ===== test/rec_ctrl_model.sv
// Controller-side model that writes parameter records byte by byte.
// Assumes the loader takes a byte at each rising mclk edge with valid high.
`timescale 1ns/1ps
module rec_ctrl_model (
    input wire logic mclk,
    input wire logic wr_ready,
    output loader_pkg::rec_wr_t wr
);
    initial wr = '0;
    // Sends the first n bytes; gap idle cycles between bytes model a slow controller.
    task automatic send(input logic [7:0] idx, input loader_pkg::rec_bytes_t rec, input int n,
        input int gap);
        while (wr_ready !== 1'b1) @(negedge mclk);
        for (int k = 0; k < n; k++) begin
            if (k > 0) begin
                repeat (gap) begin
                    @(negedge mclk);
                    wr.valid = 1'b0;
                end
            end
            @(negedge mclk);
            wr.valid = 1'b1;
            wr.first = (k == 0);
            wr.last = (k == n - 1);
            wr.index = idx;
            wr.data = rec[k];
        end
        @(negedge mclk);
        wr.valid = 1'b0;
        wr.first = 1'b0;
        wr.last = 1'b0;
        // Released lines must not look like a held byte.
        wr.data = ~wr.data;
        wr.index = ~wr.index;
    endtask : send
endmodule : rec_ctrl_model

// ===== test/tb_channel_param_record_loader.sv
// Self-checking bench for the parameter record loader.
// Assumes the controller model owns the write port; inputs change on falling mclk.
`timescale 1ns/1ps
module tb_channel_param_record_loader;
    logic mclk;
    logic rst_n;
    logic diag_readback_mode;
    loader_pkg::rec_wr_t wr;
    loader_pkg::rd_req_t rd;
    logic [loader_pkg::NUM_CH-1:0][16:0] raw_sample;
    logic wr_ready;
    loader_pkg::rec_status_t status;
    loader_pkg::rd_rsp_t rd_rsp;
    loader_pkg::chan_meas_t [loader_pkg::NUM_CH-1:0] meas;
    loader_pkg::rec_bytes_t good;
    loader_pkg::rec_bytes_t bad [11];
    logic [7:0] bad_code [11];
    int mismatches;
    int checks;
    int cycles;

    channel_param_record_loader i_dut (.mclk(mclk), .rst_n(rst_n), .wr(wr),
        .diag_readback_mode(diag_readback_mode), .rd(rd), .raw_sample(raw_sample),
        .wr_ready(wr_ready), .status(status), .rd_rsp(rd_rsp), .meas(meas));
    rec_ctrl_model i_ctrl (.mclk(mclk), .wr_ready(wr_ready), .wr(wr));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // A hung handshake ends the run here instead of spinning forever.
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            summarize();
        end
    end

    task automatic cmp(input logic [23:0] got, input logic [23:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp

    function automatic loader_pkg::rec_bytes_t mkrec(input logic [7:0] ty, input logic [7:0] rg,
        input logic [7:0] en, input logic [15:0] hi, input logic [15:0] lo);
        loader_pkg::rec_bytes_t r;
        r = loader_pkg::REC_DEFAULT;
        r[2] = ty;
        r[3] = rg;
        r[4] = en;
        r[11:8] = {lo[7:0], lo[15:8], hi[7:0], hi[15:8]};
        return r;
    endfunction : mkrec

    task automatic wrec(input logic [7:0] idx, input loader_pkg::rec_bytes_t r, input int n,
        input int gap, input logic [7:0] code);
        int t;
        i_ctrl.send(idx, r, n, gap);
        cmp(24'(wr_ready), 24'h0, "ready in check");
        t = 0;
        while (status.valid !== 1'b1 && t < 8) begin
            @(negedge mclk);
            t++;
        end
        cmp(24'({status.valid, status.index}), 24'({1'b1, idx}), "status index");
        cmp(24'(status.code), 24'(code), "status code");
    endtask : wrec

    // exp holds the error flag above the data byte.
    task automatic rbyte(input logic [7:0] idx, input logic [7:0] ofs, input logic [8:0] exp);
        @(negedge mclk);
        rd.valid = 1'b1;
        rd.index = idx;
        rd.offset = ofs;
        @(negedge mclk);
        rd.valid = 1'b0;
        cmp(24'({rd_rsp.valid, rd_rsp.err, rd_rsp.data}), 24'({1'b1, exp}), "read byte");
    endtask : rbyte

    // exp is value, overflow, underflow, wire break, limit high, limit low.
    task automatic mchk(input int ch, input logic [16:0] raw, input logic [20:0] exp);
        @(negedge mclk);
        raw_sample[ch] = raw;
        @(negedge mclk);
        cmp(24'(meas[ch]), 24'(exp), "measured value");
    endtask : mchk

    initial begin
        rst_n = 1'b0;
        diag_readback_mode = 1'b0;
        rd = '0;
        raw_sample = '0;
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        repeat (2) @(negedge mclk);
        rbyte(8'h03, 8'h02, 9'h000);
        mchk(3, 17'h00100, 21'h0);
        $display("test reset done");
        good = mkrec(8'h02, 8'h04, 8'h02, 16'h03E8, 16'hFC18);
        wrec(8'h05, good, 20, 0, 8'h00);
        rbyte(8'h05, 8'h03, 9'h004);
        mchk(5, 17'h007D0, {16'h07D0, 5'b00010});
        mchk(5, 17'h1FC17, {16'hFC17, 5'b00001});
        mchk(5, 17'h07EFF, {16'h7EFF, 5'b00010});
        mchk(5, 17'h180FF, {16'h8000, 5'b01001});
        $display("test good record done");
        bad = '{good, good, good, mkrec(8'h05, 8'h04, 8'h00, 16'h0001, 16'h0000),
            mkrec(8'h03, 8'h02, 8'h00, 16'h0001, 16'h0000),
            mkrec(8'h02, 8'h02, 8'h01, 16'h0001, 16'h0000),
            mkrec(8'h02, 8'h04, 8'h02, 16'h7EFF, 16'h0000),
            mkrec(8'h02, 8'h03, 8'h02, 16'h0001, 16'hED00),
            mkrec(8'h02, 8'h04, 8'h02, 16'h0010, 16'h0010),
            mkrec(8'h02, 8'h01, 8'h00, 16'h0001, 16'h0000),
            mkrec(8'h02, 8'h04, 8'h02, 16'h0001, 16'h8100)};
        bad[2][0] = 8'h01;
        bad_code = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h07, 8'h07, 8'h05, 8'h07};
        for (int i = 0; i < 11; i++) begin
            wrec((i == 0) ? 8'h10 : 8'h05, bad[i], (i == 1) ? 19 : 20, i % 2,
                bad_code[i]);
            rbyte(8'h05, 8'h03, 9'h004);
        end
        $display("test faulty records done");
        wrec(8'h06, mkrec(8'h02, 8'h02, 8'h00, 16'h0000, 16'hFFFF), 20, 2, 8'h00);
        rbyte(8'h05, 8'h03, 9'h004);
        mchk(5, 17'h007D0, {16'h07D0, 5'b00010});
        mchk(6, 17'h00064, {16'h0064, 5'b00000});
        mchk(6, 17'h1ED00, {16'hED00, 5'b00000});
        mchk(6, 17'h1ECFF, {16'h8000, 5'b01000});
        mchk(6, 17'h07F00, {16'h7FFF, 5'b10000});
        wrec(8'h02, mkrec(8'h03, 8'h03, 8'h00, 16'h0001, 16'h0000), 20, 0, 8'h00);
        wrec(8'h07, mkrec(8'h00, 8'hFF, 8'hFF, 16'h0000, 16'h0000), 20, 0, 8'h00);
        mchk(7, 17'h00100, 21'h0);
        $display("test other channels done");
        wrec(8'h01, mkrec(8'h02, 8'h03, 8'h01, 16'h0001, 16'h0000), 20, 0, 8'h00);
        mchk(1, 17'h1ECFF, {16'h7FFF, 5'b00100});
        diag_readback_mode = 1'b1;
        rbyte(8'h01, 8'h00, 9'h001);
        rbyte(8'h01, 8'h03, 9'h000);
        rbyte(8'h05, 8'h03, 9'h004);
        diag_readback_mode = 1'b0;
        rbyte(8'h01, 8'h03, 9'h003);
        rbyte(8'h10, 8'h00, 9'h100);
        rbyte(8'h05, 8'h14, 9'h100);
        $display("test read back done");
        summarize();
    end
endmodule : tb_channel_param_record_loader
